// >>> rtl/four_bit_exec.sv
// Notes on behaviour
// - logic op: accumulator combined with E low nibble by select XOR/OR/AND.
// - rotate right through carry: old carry into bit 3, bit 0 out.
// - complement inverts accumulator, carry untouched.
// - carry test skips next instruction when carry is zero.
// - dedicated ops clear or set carry, nothing else.
// - add immediate keeps carry, skips next when no overflow.
// - add with carry: acc plus nibble plus carry, carry-out to carry.
// - plain add of nibble into accumulator, carry untouched.
// - lookup reads rom at page, D low bits, acc; bits 7..0 to B, A.
// - lookup copies rom bit 8 to carry only when upper-bit enable set.
// - lookup occupies one stack level temporarily.
// - indexed far branch: page p, top three address bits, low nibble acc.
// - indexed near branch: same page, low nibble from accumulator.
// - direct far branch loads page and seven-bit in-page address.
// - direct near branch loads only in-page address.
// - compare immediate skips next when acc equals constant.
// - compare memory skips next when acc equals addressed nibble.
// - bit test skips next when chosen nibble bit is zero.
// - timer flag test skips when flag set, then clears flag.
// - timer write loads reload; counter too only while stopped.
// - call pushes pc plus one, bumps stack pointer, loads page and target.
// - carrier op copies accumulator bit 3 into carrier latch.
// - control op copies accumulator bits 2..0 into timer control register.
// - timer read: upper nibble to B, lower to accumulator.
// - returns pop pc; one variant also skips next unconditionally.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module four_bit_exec
  import mcu_exec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [mcu_exec_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic carrier_output_latch_out
);
  import mcu_exec_pkg::*;

  logic [3:0] acc;
  logic [3:0] b_reg;
  logic [7:0] e_reg;
  logic [2:0] d_reg;
  logic carry_flag;
  logic skip_pending;
  logic upper_rom_bit_enable;
  logic [1:0] logic_select_reg;
  logic carrier_output_latch;
  logic timer_underflow_flag;
  logic [2:0] timer_control_reg;
  logic [7:0] timer_reload_reg;
  logic [7:0] timer_counter;
  logic [9:0] pc;
  logic [1:0] stack_pointer;
  logic [4:0] dp;
  logic [9:0] rom_adr;
  logic [31:0] last_cmd;
  logic [3:0] ram [RAM_WORDS];
  logic [8:0] rom [ROM_WORDS];
  logic [9:0] return_stack [STACK_DEPTH];

  logic req;
  logic wr_fire;
  logic exec;
  logic run;
  op_e op;
  logic [6:0] imm;
  logic [2:0] page;
  logic [3:0] mem;
  logic [8:0] rom_word;
  logic [9:0] pc_seq;
  logic timer_run_bit;
  logic tf_set;
  logic [4:0] sum;
  logic [3:0] next_acc;
  logic [3:0] next_b;
  logic next_carry;
  logic [9:0] next_pc;
  logic [1:0] next_sp;
  logic cond_skip;
  logic push;
  logic [31:0] rd_data;

  function automatic logic [4:0] add5(input logic [3:0] x, input logic [3:0] y, input logic c);
    add5 = {1'b0, x} + {1'b0, y} + {4'h0, c};
  endfunction : add5

  function automatic logic [9:0] target(input logic [2:0] pg, input logic [6:0] a,
                                        input logic [3:0] low, input logic idx);
    target = idx ? {pg, a[6:4], low} : {pg, a};
  endfunction : target

  assign req = cyc_i & stb_i;
  assign wr_fire = req & we_i & ack_o & (&sel_i);
  assign exec = wr_fire && (adr_i == OFF_CMD);
  assign run = exec & ~skip_pending;
  assign op = op_e'(dat_i[CMD_OP +: 5]);
  assign imm = dat_i[CMD_IMM +: 7];
  assign page = dat_i[CMD_PAGE +: 3];
  assign mem = ram[dp];
  assign rom_word = rom[{page, d_reg, acc}];
  assign pc_seq = pc + 10'h001;
  assign timer_run_bit = timer_control_reg[0];
  assign tf_set = timer_run_bit && (timer_counter == 8'h00);

  // instruction evaluation
  always_comb
  begin
    next_acc = acc;
    next_b = b_reg;
    next_carry = carry_flag;
    next_pc = pc_seq;
    next_sp = stack_pointer;
    cond_skip = 1'b0;
    push = 1'b0;
    sum = 5'h00;
    case (op)
      OP_LOGIC:
      begin
        case (logic_select_reg)
          LO_XOR: next_acc = acc ^ e_reg[3:0];
          LO_OR: next_acc = acc | e_reg[3:0];
          default: next_acc = acc & e_reg[3:0];
        endcase
      end
      OP_ROTATE:
      begin
        next_acc = {carry_flag, acc[3:1]};
        next_carry = acc[0];
      end
      OP_COMPL: next_acc = ~acc;
      OP_SKIP_CARRY: cond_skip = ~carry_flag;
      OP_CLR_CARRY: next_carry = 1'b0;
      OP_SET_CARRY: next_carry = 1'b1;
      OP_ADD_IMM:
      begin
        sum = add5(acc, imm[3:0], 1'b0);
        next_acc = sum[3:0];
        cond_skip = ~sum[4];
      end
      OP_ADD_CARRY:
      begin
        sum = add5(acc, mem, carry_flag);
        next_acc = sum[3:0];
        next_carry = sum[4];
      end
      OP_ADD_MEM:
      begin
        sum = add5(acc, mem, 1'b0);
        next_acc = sum[3:0];
      end
      OP_LOOKUP:
      begin
        next_b = rom_word[7:4];
        next_acc = rom_word[3:0];
        if (upper_rom_bit_enable)
        begin
          next_carry = rom_word[8];
        end
      end
      OP_FAR_IDX: next_pc = target(page, imm, acc, 1'b1);
      OP_NEAR_IDX: next_pc = target(pc[9:7], imm, acc, 1'b1);
      OP_FAR: next_pc = target(page, imm, acc, 1'b0);
      OP_NEAR: next_pc = target(pc[9:7], imm, acc, 1'b0);
      OP_CMP_IMM: cond_skip = (acc == imm[3:0]);
      OP_CMP_MEM: cond_skip = (acc == mem);
      OP_BIT_TEST: cond_skip = ~mem[imm[1:0]];
      OP_SKIP_TFLAG: cond_skip = timer_underflow_flag;
      OP_RD_TIMER:
      begin
        next_b = timer_counter[7:4];
        next_acc = timer_counter[3:0];
      end
      OP_RET, OP_RET_SKIP:
      begin
        next_sp = stack_pointer - 2'h1;
        next_pc = return_stack[stack_pointer - 2'h1];
        cond_skip = (op == OP_RET_SKIP);
      end
      OP_CALL_IDX, OP_CALL:
      begin
        push = 1'b1;
        next_sp = stack_pointer + 2'h1;
        next_pc = target(page, imm, acc, op == OP_CALL_IDX);
      end
      default:
      begin
      end
    endcase
  end

  // core registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc <= 4'h0;
      b_reg <= 4'h0;
      e_reg <= 8'h00;
      d_reg <= 3'h0;
      carry_flag <= 1'b0;
      upper_rom_bit_enable <= 1'b0;
      logic_select_reg <= LO_XOR;
    end
    else if (run)
    begin
      acc <= next_acc;
      b_reg <= next_b;
      carry_flag <= next_carry;
    end
    else if (wr_fire && adr_i == OFF_STATE)
    begin
      acc <= dat_i[ST_A +: 4];
      b_reg <= dat_i[ST_B +: 4];
      e_reg <= dat_i[ST_E +: 8];
      d_reg <= dat_i[ST_D +: 3];
      carry_flag <= dat_i[ST_CY];
      upper_rom_bit_enable <= dat_i[ST_URS];
      logic_select_reg <= dat_i[ST_LO +: 2];
    end
  end

  // program counter, skip and stack
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pc <= RST_PC;
      stack_pointer <= 2'h0;
      skip_pending <= 1'b0;
    end
    else if (exec)
    begin
      pc <= run ? next_pc : pc_seq;
      skip_pending <= run & cond_skip;
      if (run)
      begin
        stack_pointer <= next_sp;
      end
    end
    else if (wr_fire && adr_i == OFF_PC)
    begin
      pc <= dat_i[9:0];
      stack_pointer <= dat_i[PC_SP +: 2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (run && (push || op == OP_LOOKUP))
    begin
      return_stack[stack_pointer] <= pc_seq;
    end
  end

  // memories and pointers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dp <= 5'h00;
      rom_adr <= 10'h000;
      last_cmd <= 32'h0000_0000;
    end
    else if (wr_fire)
    begin
      if (adr_i == OFF_DP)
      begin
        dp <= dat_i[4:0];
      end
      if (adr_i == OFF_ROM_ADR)
      begin
        rom_adr <= dat_i[9:0];
      end
      if (adr_i == OFF_ROM_DAT)
      begin
        rom_adr <= rom_adr + 10'h001;
      end
      if (adr_i == OFF_CMD)
      begin
        last_cmd <= dat_i;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr_fire && adr_i == OFF_RAM)
    begin
      ram[dp] <= dat_i[3:0];
    end
    if (wr_fire && adr_i == OFF_ROM_DAT)
    begin
      rom[rom_adr] <= dat_i[8:0];
    end
  end

  // carrier latch and timer control
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      carrier_output_latch <= 1'b0;
      timer_control_reg <= RST_TCTRL;
    end
    else if (run && op == OP_CARRIER_OUTPUT_LATCH)
    begin
      carrier_output_latch <= acc[3];
    end
    else if (run && op == OP_WR_TCTRL)
    begin
      timer_control_reg <= acc[2:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      carrier_output_latch_out <= 1'b0;
    end
    else
    begin
      carrier_output_latch_out <= carrier_output_latch;
    end
  end

  // timer 1: down counter with reload
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      timer_reload_reg <= RST_TIMER;
      timer_counter <= RST_TIMER;
    end
    else
    begin
      if (run && op == OP_WR_TIMER)
      begin
        timer_reload_reg <= {b_reg, acc};
      end
      if (run && op == OP_WR_TIMER && !timer_run_bit)
      begin
        timer_counter <= {b_reg, acc};
      end
      else if (tf_set)
      begin
        timer_counter <= timer_reload_reg;
      end
      else if (timer_run_bit)
      begin
        timer_counter <= timer_counter - 8'h01;
      end
    end
  end

  // underflow flag: a new underflow wins over the clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      timer_underflow_flag <= 1'b0;
    end
    else if (tf_set)
    begin
      timer_underflow_flag <= 1'b1;
    end
    else if (run && op == OP_SKIP_TFLAG)
    begin
      timer_underflow_flag <= 1'b0;
    end
  end

  // wishbone read path
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      OFF_CMD: rd_data = last_cmd;
      OFF_STATE:
      begin
        rd_data[ST_A +: 4] = acc;
        rd_data[ST_B +: 4] = b_reg;
        rd_data[ST_E +: 8] = e_reg;
        rd_data[ST_D +: 3] = d_reg;
        rd_data[ST_CY] = carry_flag;
        rd_data[ST_SKIP] = skip_pending;
        rd_data[ST_URS] = upper_rom_bit_enable;
        rd_data[ST_LO +: 2] = logic_select_reg;
        rd_data[ST_CARRIER_OUTPUT_LATCH] = carrier_output_latch;
        rd_data[ST_TF] = timer_underflow_flag;
      end
      OFF_PC: rd_data = {14'h0000, stack_pointer, 6'h00, pc};
      OFF_TIMER: rd_data = {13'h0000, timer_control_reg, timer_reload_reg, timer_counter};
      OFF_DP: rd_data = {27'h000_0000, dp};
      OFF_RAM: rd_data = {28'h000_0000, mem};
      OFF_ROM_ADR: rd_data = {22'h00_0000, rom_adr};
      OFF_ROM_DAT: rd_data = {23'h00_0000, rom[rom_adr]};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req & ~ack_o;
      if (req && !ack_o)
      begin
        dat_o <= rd_data;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_logic;
    run && op == OP_LOGIC && logic_select_reg == LO_XOR |=> acc == ($past(acc) ^ $past(e_reg[3:0]));
  endproperty
  a_logic: assert property (p_logic) else $error("xor result wrong");

  property p_rotate;
    run && op == OP_ROTATE |=> carry_flag == $past(acc[0]) && acc[3] == $past(carry_flag);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate wrong");

  property p_compl;
    run && op == OP_COMPL |=> acc == ~$past(acc) && $stable(carry_flag);
  endproperty
  a_compl: assert property (p_compl) else $error("complement wrong");

  property p_skip_carry;
    run && op == OP_SKIP_CARRY |=> skip_pending == !$past(carry_flag);
  endproperty
  a_skip_carry: assert property (p_skip_carry) else $error("carry skip wrong");

  property p_add_imm;
    run && op == OP_ADD_IMM |=> $stable(carry_flag) && skip_pending != $past(sum[4]);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

  property p_add_carry;
    run && op == OP_ADD_CARRY |=> {carry_flag, acc} == $past({1'b0, acc} + {1'b0, mem} + {4'h0, carry_flag});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

  property p_tflag;
    run && op == OP_SKIP_TFLAG && timer_underflow_flag && !tf_set |=> skip_pending && !timer_underflow_flag;
  endproperty
  a_tflag: assert property (p_tflag) else $error("timer flag test wrong");

  property p_timer_wr;
    run && op == OP_WR_TIMER && !timer_run_bit |=> timer_counter == $past({b_reg, acc});
  endproperty
  a_timer_wr: assert property (p_timer_wr) else $error("stopped timer not loaded");

  property p_call;
    run && op == OP_CALL |=> stack_pointer == $past(stack_pointer) + 2'h1 && pc == $past({page, imm});
  endproperty
  a_call: assert property (p_call) else $error("call wrong");

  property p_skip_nop;
    exec && skip_pending |=> $stable(acc) && $stable(carry_flag) && !skip_pending && pc == $past(pc_seq);
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped op changed state");

  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  c_lookup: cover property (run && op == OP_LOOKUP && upper_rom_bit_enable);
  c_skipped: cover property (exec && skip_pending);
  c_call_ret: cover property (run && op == OP_CALL ##[1:40] run && op == OP_RET);
  c_underflow: cover property (tf_set);
endmodule : four_bit_exec

// >>> shared/mcu_exec_pkg.sv
package mcu_exec_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_TIMER = 8'h0c;
  localparam logic [7:0] OFF_DP = 8'h10;
  localparam logic [7:0] OFF_RAM = 8'h14;
  localparam logic [7:0] OFF_ROM_ADR = 8'h18;
  localparam logic [7:0] OFF_ROM_DAT = 8'h1c;
  localparam int ROM_WORDS = 1024;
  localparam int RAM_WORDS = 32;
  localparam int STACK_DEPTH = 4;
  // command word fields
  localparam int CMD_OP = 0;
  localparam int CMD_IMM = 8;
  localparam int CMD_PAGE = 16;
  // state word fields
  localparam int ST_A = 0;
  localparam int ST_B = 4;
  localparam int ST_E = 8;
  localparam int ST_D = 16;
  localparam int ST_CY = 20;
  localparam int ST_SKIP = 21;
  localparam int ST_URS = 22;
  localparam int ST_LO = 24;
  localparam int ST_CARRIER_OUTPUT_LATCH = 26;
  localparam int ST_TF = 27;
  // pc word and timer word fields
  localparam int PC_SP = 16;
  localparam int TM_CNT = 0;
  localparam int TM_RLD = 8;
  localparam int TM_CTL = 16;
  // reset values
  localparam logic [9:0] RST_PC = 10'h000;
  localparam logic [2:0] RST_TCTRL = 3'h0;
  localparam logic [7:0] RST_TIMER = 8'hff;
  // logic-select codes
  localparam logic [1:0] LO_XOR = 2'h0;
  localparam logic [1:0] LO_OR = 2'h1;
  localparam logic [1:0] LO_AND = 2'h2;
  typedef enum logic [4:0] {
    OP_NOP, OP_LOGIC, OP_ROTATE, OP_COMPL, OP_SKIP_CARRY, OP_CLR_CARRY, OP_SET_CARRY,
    OP_ADD_IMM, OP_ADD_CARRY, OP_ADD_MEM, OP_LOOKUP, OP_FAR_IDX, OP_NEAR_IDX, OP_FAR,
    OP_NEAR, OP_CMP_IMM, OP_CMP_MEM, OP_BIT_TEST, OP_SKIP_TFLAG, OP_WR_TIMER, OP_RD_TIMER,
    OP_CARRIER_OUTPUT_LATCH, OP_WR_TCTRL, OP_RET, OP_RET_SKIP, OP_CALL_IDX, OP_CALL
  } op_e;
endpackage : mcu_exec_pkg

// >>> bench/wb_host.sv
`timescale 1ns/100ps
// classic wishbone master for the execution block
module wb_host
  import mcu_exec_pkg::*;
(
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [ADDR_W-1:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h0;
  end

  // request held until ack is sampled high
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer
endmodule : wb_host

// >>> bench/four_bit_mcu_instruction_exec_tb.sv
`timescale 1ns/100ps
module four_bit_mcu_instruction_exec_tb;
  import mcu_exec_pkg::*;
  localparam logic [31:0] skip_bit = 32'h0020_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc;
  logic stb;
  logic we;
  logic [ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic carrier;
  logic [31:0] q;
  logic [3:0] lr [4] = '{4'h6, 4'he, 4'h8, 4'h8};
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  four_bit_exec i_dut (.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .carrier_output_latch_out(carrier));

  wb_host i_host (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .wdat(wdat));

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_host.xfer(1'b1, a, d, 4'hf, r);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    i_host.xfer(1'b0, a, 32'h0, 4'hf, r);
    cmp(r & m, e);
  endtask : chk

  task automatic ex(input op_e op, input logic [6:0] a, input logic [2:0] p);
    wr(OFF_CMD, {13'h0, p, 1'b0, a, 3'h0, op});
  endtask : ex

  function automatic logic [31:0] st(input logic [3:0] a, input logic [3:0] b, input logic [7:0] e,
                                     input logic [2:0] d, input logic c, input logic u, input logic [1:0] l);
    return {6'h0, l, 1'b0, u, 1'b0, c, 1'b0, d, e, b, a};
  endfunction : st

  function automatic logic [31:0] pcw(input logic [1:0] s, input logic [9:0] p);
    return {14'h0, s, 6'h0, p};
  endfunction : pcw

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("BAD %0t run timed out", $time);
      print_verdict();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(OFF_STATE, '1, 32'h0);
    chk(OFF_TIMER, 32'h0007_ffff, 32'h0000_ffff);
    chk(8'h40, '1, 32'h0);
    i_host.xfer(1'b1, OFF_STATE, 32'h0000_000f, 4'h3, q);
    chk(OFF_STATE, '1, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_STATE, st(4'hc, 4'h0, 8'h3a, 3'h0, 1'b1, 1'b0, i[1:0]));
      ex(OP_LOGIC, 7'h0, 3'h0);
      chk(OFF_STATE, '1, st(lr[i], 4'h0, 8'h3a, 3'h0, 1'b1, 1'b0, i[1:0]));
    end
    wr(OFF_STATE, st(4'h5, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    ex(OP_ROTATE, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'ha, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    ex(OP_ROTATE, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'hd, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    wr(OFF_STATE, st(4'h3, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    ex(OP_COMPL, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'hc, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    wr(OFF_STATE, st(4'h6, 4'h9, 8'h21, 3'h3, 1'b0, 1'b0, 2'h1));
    ex(OP_SET_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'h6, 4'h9, 8'h21, 3'h3, 1'b1, 1'b0, 2'h1));
    ex(OP_CLR_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'h6, 4'h9, 8'h21, 3'h3, 1'b0, 1'b0, 2'h1));
    wr(OFF_PC, 32'h0);
    ex(OP_SKIP_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'h6, 4'h9, 8'h21, 3'h3, 1'b0, 1'b0, 2'h1) | skip_bit);
    ex(OP_SET_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'h6, 4'h9, 8'h21, 3'h3, 1'b0, 1'b0, 2'h1));
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h002));
    wr(OFF_STATE, st(4'h6, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    ex(OP_SKIP_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, skip_bit, 32'h0);
    wr(OFF_STATE, st(4'he, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_ADD_IMM, 7'h3, 3'h0);
    chk(OFF_STATE, '1, st(4'h1, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    wr(OFF_STATE, st(4'hc, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    ex(OP_ADD_IMM, 7'h3, 3'h0);
    chk(OFF_STATE, '1, st(4'hf, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0) | skip_bit);
    ex(OP_NOP, 7'h0, 3'h0);
    wr(OFF_DP, 32'h5);
    wr(OFF_RAM, 32'h9);
    chk(OFF_DP, '1, 32'h5);
    wr(OFF_STATE, st(4'h8, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    ex(OP_ADD_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'h2, 4'h0, 8'h0, 3'h0, 1'b1, 1'b0, 2'h0));
    wr(OFF_STATE, st(4'h6, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_ADD_CARRY, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'hf, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    wr(OFF_STATE, st(4'h8, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_ADD_MEM, 7'h0, 3'h0);
    chk(OFF_STATE, '1, st(4'h1, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    chk(OFF_RAM, 32'hf, 32'h9);
    wr(OFF_STATE, st(4'h7, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_CMP_IMM, 7'h7, 3'h0);
    chk(OFF_STATE, skip_bit, skip_bit);
    ex(OP_NOP, 7'h0, 3'h0);
    ex(OP_CMP_IMM, 7'h6, 3'h0);
    chk(OFF_STATE, skip_bit, 32'h0);
    wr(OFF_STATE, st(4'h9, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_CMP_MEM, 7'h0, 3'h0);
    chk(OFF_STATE, skip_bit, skip_bit);
    ex(OP_NOP, 7'h0, 3'h0);
    for (int j = 0; j < 4; j++)
    begin
      ex(OP_BIT_TEST, j[6:0], 3'h0);
      chk(OFF_STATE, skip_bit, ((4'h9 >> j) & 4'h1) == 4'h0 ? skip_bit : 32'h0);
      ex(OP_NOP, 7'h0, 3'h0);
    end
    wr(OFF_ROM_ADR, 32'h153);
    wr(OFF_ROM_DAT, 32'h1a5);
    chk(OFF_ROM_ADR, '1, 32'h154);
    wr(OFF_PC, 32'h005);
    ex(OP_CALL, 7'h20, 3'h2);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h1, 10'h120));
    wr(OFF_STATE, st(4'h3, 4'h0, 8'h0, 3'h5, 1'b0, 1'b0, 2'h0));
    ex(OP_LOOKUP, 7'h0, 3'h2);
    chk(OFF_STATE, '1, st(4'h5, 4'ha, 8'h0, 3'h5, 1'b0, 1'b0, 2'h0));
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h1, 10'h121));
    wr(OFF_STATE, st(4'h3, 4'h0, 8'h0, 3'h5, 1'b0, 1'b1, 2'h0));
    ex(OP_LOOKUP, 7'h0, 3'h2);
    chk(OFF_STATE, '1, st(4'h5, 4'ha, 8'h0, 3'h5, 1'b1, 1'b1, 2'h0));
    ex(OP_RET, 7'h0, 3'h0);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h006));
    wr(OFF_STATE, st(4'h7, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_CALL_IDX, 7'h30, 3'h1);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h1, 10'h0b7));
    ex(OP_RET_SKIP, 7'h0, 3'h0);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h007));
    chk(OFF_STATE, skip_bit, skip_bit);
    ex(OP_NOP, 7'h0, 3'h0);
    wr(OFF_STATE, st(4'ha, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_FAR_IDX, 7'h55, 3'h3);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h1da));
    ex(OP_NEAR_IDX, 7'h21, 3'h0);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h1aa));
    ex(OP_FAR, 7'h7f, 3'h1);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h0ff));
    ex(OP_NEAR, 7'h11, 3'h5);
    chk(OFF_PC, 32'h0003_03ff, pcw(2'h0, 10'h091));
    wr(OFF_STATE, st(4'h8, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_CARRIER_OUTPUT_LATCH, 7'h0, 3'h0);
    chk(OFF_STATE, 32'h0400_0000, 32'h0400_0000);
    cmp({31'h0, carrier}, 32'h1);
    wr(OFF_STATE, st(4'h7, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_CARRIER_OUTPUT_LATCH, 7'h0, 3'h0);
    chk(OFF_STATE, 32'h0400_0000, 32'h0);
    cmp({31'h0, carrier}, 32'h0);
    wr(OFF_STATE, st(4'h4, 4'h2, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_WR_TIMER, 7'h0, 3'h0);
    chk(OFF_TIMER, 32'h0007_ffff, 32'h0000_2424);
    wr(OFF_STATE, st(4'h1, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_RD_TIMER, 7'h0, 3'h0);
    chk(OFF_STATE, 32'hff, 32'h24);
    ex(OP_WR_TCTRL, 7'h0, 3'h0);
    chk(OFF_TIMER, 32'h0007_0000, 32'h0004_0000);
    wr(OFF_STATE, st(4'h1, 4'h0, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_WR_TCTRL, 7'h0, 3'h0);
    wr(OFF_STATE, st(4'h0, 4'h5, 8'h0, 3'h0, 1'b0, 1'b0, 2'h0));
    ex(OP_WR_TIMER, 7'h0, 3'h0);
    chk(OFF_TIMER, 32'h0007_ff00, 32'h0001_5000);
    q = 32'h0;
    for (int k = 0; k < 200 && q[27] !== 1'b1; k++)
      i_host.xfer(1'b0, OFF_STATE, 32'h0, 4'hf, q);
    ex(OP_SKIP_TFLAG, 7'h0, 3'h0);
    chk(OFF_STATE, 32'h0820_0000, skip_bit);
    ex(OP_NOP, 7'h0, 3'h0);
    wr(OFF_STATE, 32'h0);
    ex(OP_WR_TCTRL, 7'h0, 3'h0);
    ex(OP_SKIP_TFLAG, 7'h0, 3'h0);
    chk(OFF_STATE, skip_bit, 32'h0);
    chk(OFF_CMD, '1, {27'h0, OP_SKIP_TFLAG});
    print_verdict();
  end
endmodule : four_bit_mcu_instruction_exec_tb
